// file: design/ddm_pkg.sv
/*
 * Shared constants and types for the drive detect and monitor select block:
 * register offsets, reset values, source codes, timing and packed carriers.
 * Assumes a single 50 MHz control clock.
 */
`default_nettype none
package ddm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_TORQ_THR  = 8'h00;
    localparam logic [7:0] OFS_SPD_THR   = 8'h04;
    localparam logic [7:0] OFS_LOW_THR   = 8'h08;
    localparam logic [7:0] OFS_SELECT    = 8'h0C;
    localparam logic [7:0] OFS_SPD_REF   = 8'h10;
    localparam logic [7:0] OFS_CUR_REF   = 8'h14;
    localparam logic [7:0] OFS_TORQ_REF  = 8'h18;
    localparam logic [7:0] OFS_VOLT_SCL  = 8'h1C;
    localparam logic [7:0] OFS_FILT_TIME = 8'h20;
    localparam logic [7:0] OFS_WPROT     = 8'h24;
    localparam logic [7:0] OFS_MACH_SCL  = 8'h28;
    localparam logic [7:0] OFS_STATUS    = 8'h2C;
    // Select register field positions, 5 bits each
    localparam int SEL_LED_LSB  = 0;
    localparam int SEL_MAIN_LSB = 5;
    localparam int SEL_MTR_LSB  = 10;
    localparam int SEL_DA1_LSB  = 15;
    localparam int SEL_DA2_LSB  = 20;
    // Reset values and limits
    localparam logic [15:0] RST_TORQ_THR  = 16'h0096;
    localparam logic [15:0] RST_SPD_THR   = 16'h012C;
    localparam logic [15:0] RST_LOW_THR   = 16'h002D;
    localparam logic [24:0] RST_SELECT    = 25'h0708401;
    localparam logic [15:0] RST_SPD_REF   = 16'h05DC;
    localparam logic [15:0] RST_CUR_REF   = 16'h0064;
    localparam logic [15:0] RST_TORQ_REF  = 16'h0096;
    localparam logic [15:0] RST_FILT_TIME = 16'h270F;
    localparam logic [15:0] RST_MACH_SCL  = 16'h270F;
    localparam logic [15:0] MAX_SPD_THR   = 16'h0E10;
    localparam logic [15:0] MAX_LOW_THR   = 16'h05DC;
    localparam logic [15:0] MAX_FILT_TIME = 16'h1388;
    localparam logic [15:0] SETTING_AUTO  = 16'h270F;
    localparam logic [15:0] WPROT_UNLOCK  = 16'h0321;
    localparam logic [15:0] MACH_SCL_MIN  = 16'h000B;
    localparam logic [31:0] MACH_REF_RPM  = 32'h000005DC;
    localparam logic [31:0] DISP_MAX      = 32'h0000270F;
    localparam logic [15:0] VOLT_FS_LO    = 16'h0190;
    localparam logic [15:0] VOLT_FS_HI    = 16'h0320;
    localparam logic [11:0] DA1_MID       = 12'h800;
    // Timing
    localparam int CLK_NS         = 20;
    localparam int TICK_NS        = 1000000;
    localparam int TICK_CYCLES    = TICK_NS / CLK_NS;
    localparam int BLINK_MS       = 500;
    localparam logic [15:0] FILT_AUTO_MS = 16'h0032;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        SRC_NONE    = 5'h00,
        SRC_SPEED   = 5'h01,
        SRC_CURRENT = 5'h02,
        SRC_VOLTAGE = 5'h03,
        SRC_SET_SPD = 5'h05,
        SRC_FREQ    = 5'h06,
        SRC_TORQUE  = 5'h07,
        SRC_DC_BUS  = 5'h08,
        SRC_LOAD    = 5'h11,
        SRC_REF_V   = 5'h15
    } ddm_src_t;

    typedef struct packed {
        logic signed [15:0] speed;
        logic signed [15:0] set_speed;
        logic signed [15:0] torque;
        logic signed [15:0] load;
        logic [15:0]        freq;
        logic [15:0]        current;
        logic [15:0]        voltage;
        logic [15:0]        dc_bus;
        logic [15:0]        ref_volt;
    } ddm_meas_t;

    typedef struct packed {
        logic [15:0] mag;
        logic [15:0] fs;
        logic        neg;
        logic        bipolar;
    } ddm_pick_t;
endpackage
`default_nettype wire

// file: design/ddm_top.sv
/*
 * Drive status detection and monitor selection: three open-collector flags,
 * a five-way monitor selector, scaled analog codes with a filtered primary
 * output, and machine-speed display scaling, behind an AXI4-Lite slave.
 * Assumes measurements come from logic on the same clock with a valid strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module ddm_top
    import ddm_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire ddm_meas_t   meas,
    input  wire logic        meas_valid,
    output logic             over_torque_flag_oe,
    output logic             speed_reached_flag_oe,
    output logic             low_speed_flag_oe,
    output logic [15:0]      led_display,
    output logic [15:0]      operator_panel_main,
    output logic [11:0]      operator_panel_meter,
    output logic [11:0]      analog_out_primary,
    output logic [7:0]       analog_out_secondary
);
    if (TICK_LEN < 2) begin : g_tick_len_check
        $error("TICK_LEN must be at least 2");
    end

    logic [15:0] torq_thr_q, spd_thr_q, low_thr_q, spd_ref_q, cur_ref_q, torq_ref_q;
    logic [15:0] filt_time_q, wprot_q, mach_scl_q;
    logic [24:0] select_q;
    logic        volt_hi_q;
    ddm_meas_t   meas_q;

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction

    // Value over full scale, saturating at 4095
    function automatic logic [11:0] scale12(input logic [15:0] mag, input logic [15:0] fs);
        logic [31:0] q;
        // Zero magnitude gives zero, so unsupported codes read as zero
        q = (mag == 16'h0000) ? 32'h00000000
            : (fs == 16'h0000) ? 32'hFFFFFFFF : ((32'(mag) * 32'h00000FFF) / 32'(fs));
        return (q > 32'h00000FFF) ? 12'hFFF : q[11:0];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction

    // Shift giving a time constant near the setting in ms
    function automatic logic [3:0] filt_shift(input logic [15:0] ms);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 13; i++) begin
            if ((32'h00000001 << i) < 32'(ms)) s = 4'(i + 1);
        end
        return s;
    endfunction

    function automatic ddm_pick_t pick(input logic [4:0] code, input ddm_meas_t m);
        ddm_pick_t p;
        p = '0;
        unique case (code)
            SRC_SPEED: begin
                p = '{abs16(m.speed), spd_ref_q, m.speed[15], 1'b1};
            end
            SRC_SET_SPD: begin
                p = '{abs16(m.set_speed), spd_ref_q, m.set_speed[15], 1'b0};
            end
            SRC_FREQ: begin
                p = '{m.freq, spd_ref_q, 1'b0, 1'b0};
            end
            SRC_CURRENT: begin
                p = '{m.current, cur_ref_q, 1'b0, 1'b0};
            end
            SRC_VOLTAGE: begin
                p = '{m.voltage, volt_hi_q ? VOLT_FS_HI : VOLT_FS_LO, 1'b0, 1'b0};
            end
            SRC_DC_BUS: begin
                p = '{m.dc_bus, volt_hi_q ? VOLT_FS_HI : VOLT_FS_LO, 1'b0, 1'b0};
            end
            SRC_TORQUE: begin
                p = '{abs16(m.torque), torq_ref_q, m.torque[15], 1'b1};
            end
            SRC_LOAD: begin
                p = '{abs16(m.load), torq_ref_q, m.load[15], 1'b1};
            end
            SRC_REF_V: begin
                p = '{m.ref_volt, volt_hi_q ? VOLT_FS_HI : VOLT_FS_LO, 1'b0, 1'b0};
            end
            default: begin
                p = '0;
            end
        endcase
        return p;
    endfunction

    // ---------------- AXI4-Lite slave ----------------
    logic        aw_held_q, w_held_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        do_write;
    logic [31:0] wval;
    logic        wr_ok;
    logic [31:0] rd_val;
    logic        rd_ok;

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Write decode with range checks; refused values leave the register as is
    always_comb begin
        wval  = 32'h00000000;
        wr_ok = 1'b1;
        unique case (awaddr_q)
            OFS_TORQ_THR:  wval = merge({16'h0000, torq_thr_q}, wdata_q, wstrb_q);
            OFS_SPD_THR:   wval = merge({16'h0000, spd_thr_q}, wdata_q, wstrb_q);
            OFS_LOW_THR:   wval = merge({16'h0000, low_thr_q}, wdata_q, wstrb_q);
            OFS_SELECT:    wval = merge({7'h00, select_q}, wdata_q, wstrb_q);
            OFS_SPD_REF:   wval = merge({16'h0000, spd_ref_q}, wdata_q, wstrb_q);
            OFS_CUR_REF:   wval = merge({16'h0000, cur_ref_q}, wdata_q, wstrb_q);
            OFS_TORQ_REF:  wval = merge({16'h0000, torq_ref_q}, wdata_q, wstrb_q);
            OFS_VOLT_SCL:  wval = merge({31'h00000000, volt_hi_q}, wdata_q, wstrb_q);
            OFS_FILT_TIME: wval = merge({16'h0000, filt_time_q}, wdata_q, wstrb_q);
            OFS_WPROT:     wval = merge({16'h0000, wprot_q}, wdata_q, wstrb_q);
            OFS_MACH_SCL:  wval = merge({16'h0000, mach_scl_q}, wdata_q, wstrb_q);
            default:       wr_ok = 1'b0;
        endcase
        unique case (awaddr_q)
            OFS_SPD_THR:   wr_ok = wval[15:0] <= MAX_SPD_THR;
            OFS_LOW_THR:   wr_ok = wval[15:0] <= MAX_LOW_THR;
            OFS_FILT_TIME: wr_ok = (wprot_q == WPROT_UNLOCK)
                                   && (wval[15:0] <= MAX_FILT_TIME
                                       || wval[15:0] == SETTING_AUTO);
            OFS_MACH_SCL:  wr_ok = wval[15:0] >= MACH_SCL_MIN
                                   && wval[15:0] <= SETTING_AUTO;
            default:       wr_ok = wr_ok;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            torq_thr_q  <= RST_TORQ_THR;
            spd_thr_q   <= RST_SPD_THR;
            low_thr_q   <= RST_LOW_THR;
            select_q    <= RST_SELECT;
            spd_ref_q   <= RST_SPD_REF;
            cur_ref_q   <= RST_CUR_REF;
            torq_ref_q  <= RST_TORQ_REF;
            volt_hi_q   <= 1'b0;
            filt_time_q <= RST_FILT_TIME;
            wprot_q     <= 16'h0000;
            mach_scl_q  <= RST_MACH_SCL;
        end else if (do_write && wr_ok) begin
            unique case (awaddr_q)
                OFS_TORQ_THR:  torq_thr_q  <= wval[15:0];
                OFS_SPD_THR:   spd_thr_q   <= wval[15:0];
                OFS_LOW_THR:   low_thr_q   <= wval[15:0];
                OFS_SELECT:    select_q    <= wval[24:0];
                OFS_SPD_REF:   spd_ref_q   <= wval[15:0];
                OFS_CUR_REF:   cur_ref_q   <= wval[15:0];
                OFS_TORQ_REF:  torq_ref_q  <= wval[15:0];
                OFS_VOLT_SCL:  volt_hi_q   <= wval[0];
                OFS_FILT_TIME: filt_time_q <= wval[15:0];
                OFS_WPROT:     wprot_q     <= wval[15:0];
                OFS_MACH_SCL:  mach_scl_q  <= wval[15:0];
                default:       wprot_q     <= wprot_q;
            endcase
        end
    end

    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h00000000;
        unique case (s_axi_araddr)
            OFS_TORQ_THR:  rd_val = {16'h0000, torq_thr_q};
            OFS_SPD_THR:   rd_val = {16'h0000, spd_thr_q};
            OFS_LOW_THR:   rd_val = {16'h0000, low_thr_q};
            OFS_SELECT:    rd_val = {7'h00, select_q};
            OFS_SPD_REF:   rd_val = {16'h0000, spd_ref_q};
            OFS_CUR_REF:   rd_val = {16'h0000, cur_ref_q};
            OFS_TORQ_REF:  rd_val = {16'h0000, torq_ref_q};
            OFS_VOLT_SCL:  rd_val = {31'h00000000, volt_hi_q};
            OFS_FILT_TIME: rd_val = {16'h0000, filt_time_q};
            OFS_WPROT:     rd_val = {16'h0000, wprot_q};
            OFS_MACH_SCL:  rd_val = {16'h0000, mach_scl_q};
            OFS_STATUS:    rd_val = {29'h00000000, low_speed_flag_oe,
                                     speed_reached_flag_oe, over_torque_flag_oe};
            default:       rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ---------------- Detection flags ----------------
    // latch latest measurement and re-evaluate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_q                <= '0;
            over_torque_flag_oe   <= 1'b0;
            speed_reached_flag_oe <= 1'b0;
            low_speed_flag_oe     <= 1'b0;
        end else if (meas_valid) begin
            meas_q                <= meas;
            // transistor on while torque exceeds threshold
            over_torque_flag_oe   <= meas.torque > $signed(torq_thr_q);
            speed_reached_flag_oe <= abs16(meas.speed) >= spd_thr_q;
            low_speed_flag_oe     <= abs16(meas.speed) < low_thr_q;
        end
    end

    // ---------------- Millisecond tick and blink ----------------
    logic [31:0] tick_cnt_q;
    logic        tick_q;
    logic [9:0]  blink_cnt_q;
    logic        blink_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= tick_cnt_q == 32'(TICK_LEN - 1);
            tick_cnt_q <= (tick_cnt_q == 32'(TICK_LEN - 1)) ? 32'h00000000 : tick_cnt_q + 1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_q <= 10'h000;
            blink_q     <= 1'b0;
        end else if (tick_q) begin
            blink_cnt_q <= (blink_cnt_q == 10'(BLINK_MS - 1)) ? 10'h000 : blink_cnt_q + 10'h001;
            if (blink_cnt_q == 10'(BLINK_MS - 1)) blink_q <= !blink_q;
        end
    end

    // ---------------- Monitor outputs ----------------
    ddm_pick_t   led_p, main_p, mtr_p, da1_p, da2_p;
    logic [31:0] mach_spd;
    logic [15:0] spd_disp;
    logic [11:0] da1_u, da1_code, da2_u;
    logic [4:0]  main_code;

    // independent selection per destination
    // A process, so reference registers read inside pick wake it too
    always_comb begin
        main_code = (select_q[SEL_MAIN_LSB +: 5] == 5'h00) ? SRC_SPEED
                    : select_q[SEL_MAIN_LSB +: 5];
        led_p     = pick(select_q[SEL_LED_LSB +: 5], meas_q);
        main_p    = pick(main_code, meas_q);
        mtr_p     = pick(select_q[SEL_MTR_LSB +: 5], meas_q);
        da1_p     = pick(select_q[SEL_DA1_LSB +: 5], meas_q);
        da2_p     = pick(select_q[SEL_DA2_LSB +: 5], meas_q);
    end

    // machine speed per 1500 rpm of motor speed
    assign mach_spd = (32'(abs16(meas_q.speed)) * 32'(mach_scl_q)) / MACH_REF_RPM;

    always_comb begin
        if (mach_scl_q == SETTING_AUTO) begin
            spd_disp = abs16(meas_q.speed);
        end else if (mach_spd > DISP_MAX) begin
            // four digits alternate 0 and 9999
            spd_disp = blink_q ? DISP_MAX[15:0] : 16'h0000;
        end else begin
            spd_disp = mach_spd[15:0];
        end
    end

    assign da1_u    = scale12(da1_p.mag, da1_p.fs);
    assign da1_code = !da1_p.bipolar ? da1_u
                      : (da1_p.neg ? DA1_MID - 12'(da1_u[11:1])
                                   : DA1_MID + 12'(da1_u[11:1]));
    assign da2_u    = scale12(da2_p.mag, da2_p.fs);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_display          <= 16'h0000;
            operator_panel_main  <= 16'h0000;
            operator_panel_meter <= 12'h000;
            analog_out_secondary <= 8'h00;
        end else begin
            led_display <= (select_q[SEL_LED_LSB +: 5] == SRC_SPEED) ? spd_disp : led_p.mag;
            operator_panel_main  <= (main_code == SRC_SPEED) ? spd_disp : main_p.mag;
            operator_panel_meter <= scale12(mtr_p.mag, mtr_p.fs);
            analog_out_secondary <= da2_u[11:4];
        end
    end

    // first-order filter stepped each millisecond, 4 fraction bits
    logic [15:0]        filt_y_q;
    logic signed [17:0] filt_err;
    logic [3:0]         filt_s;

    assign filt_s   = filt_shift((filt_time_q == SETTING_AUTO) ? FILT_AUTO_MS : filt_time_q);
    assign filt_err = $signed({2'b00, da1_code, 4'h0}) - $signed({2'b00, filt_y_q});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_y_q           <= 16'h0000;
            analog_out_primary <= 12'h000;
        end else begin
            if (filt_s == 4'h0) begin
                filt_y_q <= {da1_code, 4'h0};
            end else if (tick_q) begin
                filt_y_q <= 16'($signed({2'b00, filt_y_q}) + (filt_err >>> filt_s));
            end
            analog_out_primary <= filt_y_q[15:4];
        end
    end
endmodule
`default_nettype wire

// file: sim/ddm_flag_reader.sv
/* Relay side of the three open-collector flags, seen as pin levels.
   Assumes the pins have pull-ups at the receiving end. */
`timescale 1ns/1ns
`default_nettype none
module ddm_flag_reader (
    input  wire logic       over_oe,
    input  wire logic       reached_oe,
    input  wire logic       low_oe,
    output logic      [2:0] flag_pin_n
);
    assign flag_pin_n = ~{low_oe, reached_oe, over_oe};
endmodule
`default_nettype wire

// file: sim/ddm_top_monitor.sv
/* Port checker for ddm_top: bus handshakes, flag hold and status read.
   Bound to every ddm_top instance. */
`timescale 1ns/1ns
`default_nettype none
module ddm_top_monitor
    import ddm_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        meas_valid,
    input wire logic        over_torque_flag_oe,
    input wire logic        speed_reached_flag_oe,
    input wire logic        low_speed_flag_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_flag_hold: assert property (!meas_valid |=> $stable({over_torque_flag_oe,
        speed_reached_flag_oe, low_speed_flag_oe})) else $error("flags moved");
    chk_status_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == OFS_STATUS && !meas_valid |=> s_axi_rdata[2:0] ==
        {low_speed_flag_oe, speed_reached_flag_oe, over_torque_flag_oe}) else $error("status");
    chk_reset_idle: assert property ($rose(aresetn) |-> !over_torque_flag_oe &&
        !speed_reached_flag_oe && !low_speed_flag_oe && s_axi_awready) else $error("reset");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
endmodule
bind ddm_top ddm_top_monitor ddm_top_monitor_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .meas_valid, .over_torque_flag_oe, .speed_reached_flag_oe, .low_speed_flag_oe);
`default_nettype wire

// file: sim/tb_drive_detect_and_monitor_select.sv
/* Self-checking bench for ddm_top: registers, flags, selector, scaling.
   Assumes the checker is bound and the flag reader model is present. */
`timescale 1ns/1ns
`default_nettype none
module tb_drive_detect_and_monitor_select;
    import ddm_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, meas_valid = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic over_torque_flag_oe, speed_reached_flag_oe, low_speed_flag_oe;
    logic [15:0] led_display, operator_panel_main;
    logic [11:0] operator_panel_meter, analog_out_primary;
    logic [7:0] analog_out_secondary;
    logic [2:0] flag_pin_n;
    logic [4:0] codes [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
                               5'h11, 5'h15};
    ddm_meas_t meas = '{16'h05DC, 16'h05DC, 16'h0096, 16'h0096, 16'h05DC,
                        16'h0064, 16'h0190, 16'h0190, 16'h0190};
    int bad_count = 0, n_compared = 0;
    always #10 aclk = ~aclk;
    ddm_top #(.TICK_LEN(10)) ddm_top_inst (.*);
    ddm_flag_reader ddm_flag_reader_inst (.over_oe(over_torque_flag_oe),
        .reached_oe(speed_reached_flag_oe), .low_oe(low_speed_flag_oe), .flag_pin_n);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
            if (!wd && s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask
    task automatic upd(input logic [15:0] sp, input logic [15:0] tq);
        @(posedge aclk);
        meas.speed <= sp;
        meas.torque <= tq;
        meas_valid <= 1;
        @(posedge aclk);
        meas_valid <= 0;
        repeat (4) @(posedge aclk);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        $display("mismatch at %0t: timeout", $time);
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_SPD_THR, 32'h12C, RESP_OKAY);
        rd(OFS_LOW_THR, 32'h2D, RESP_OKAY);
        rd(OFS_SELECT, 32'h708401, RESP_OKAY);
        rd(OFS_FILT_TIME, 32'h270F, RESP_OKAY);
        rd(OFS_MACH_SCL, 32'h270F, RESP_OKAY);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(OFS_SPD_THR, 32'hE11, RESP_SLVERR);
        wr(OFS_SPD_THR, 32'hE10, RESP_OKAY);
        rd(OFS_SPD_THR, 32'hE10, RESP_OKAY);
        wr(OFS_LOW_THR, 32'h5DD, RESP_SLVERR);
        wr(OFS_SPD_THR, 32'h12C, RESP_OKAY);
        upd(16'h012C, 16'h0097);
        chk(flag_pin_n, 3'b100);
        upd(16'h012B, 16'h0096);
        chk(flag_pin_n, 3'b111);
        upd(16'h002C, 16'h0000);
        chk(flag_pin_n, 3'b011);
        upd(16'hFED4, 16'h0000);
        chk(flag_pin_n, 3'b101);
        rd(OFS_STATUS, 32'h2, RESP_OKAY);
        wr(OFS_FILT_TIME, 32'h0, RESP_SLVERR);
        wr(OFS_WPROT, 32'h321, RESP_OKAY);
        wr(OFS_FILT_TIME, 32'h0, RESP_OKAY);
        wr(OFS_WPROT, 32'h0, RESP_OKAY);
        foreach (codes[i]) begin
            wr(OFS_SELECT, {7'h0, codes[i], 20'h38401}, RESP_OKAY);
            upd(16'h05DC, 16'h0096);
            chk(analog_out_secondary, (codes[i] == 5'h04) ? 8'h00 : 8'hFF);
            chk(analog_out_primary, 12'hFFF);
        end
        wr(OFS_VOLT_SCL, 32'h1, RESP_OKAY);
        upd(16'h05DC, 16'h0000);
        chk(analog_out_secondary, 8'h7F);
        chk(analog_out_primary, 12'h800);
        chk(led_display, 16'h05DC);
        chk(operator_panel_main, 16'h05DC);
        chk(operator_panel_meter, 12'hFFF);
        upd(16'hFA24, 16'hFF6A);
        chk(analog_out_primary, 12'h001);
        wr(OFS_MACH_SCL, 32'hBB8, RESP_OKAY);
        upd(16'h01F4, 16'h0000);
        chk(led_display, 16'h03E8);
        upd(16'h1770, 16'h0000);
        chk(led_display, 16'h0000);
        repeat (BLINK_MS * 10) @(posedge aclk);
        chk(led_display, 16'h270F);
        chk(operator_panel_main, 16'h270F);
        give_verdict();
    end
endmodule
`default_nettype wire
